// ===== logic/nvmac_top.sv
// Memory access control and power-up configuration of a small controller.
`timescale 1ns/1ns
`default_nettype none
`include "nvmac_consts.svh"
module nvmac_top #(
	parameter logic [7:0] CFG1_INIT = `NVMAC_CFG1_RESET,
	parameter logic [7:0] TRIM_INIT = `NVMAC_TRIM_RESET,
	parameter int EE_CYCLES = `NVMAC_EE_WRITE_CYC
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [13:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Pins.
	input wire logic prog_mode_i,
	input wire logic brownout_i,
	// Configuration outputs.
	output logic low_battery_detect_on_o,
	output logic brownout_reset_o,
	output logic watchdog_on_o,
	output logic [1:0] clock_mode_select_o,
	output logic [7:0] osc_trim_o,
	// Interrupt.
	output logic irq_o
);
	nvmac_pkg::nvmac_state_type state;
	nvmac_pkg::nvmac_region_type region;
	nvmac_pkg::nvmac_region_type resp_region;
	nvmac_pkg::nvmac_cfg_type nv_cfg = CFG1_INIT;
	nvmac_pkg::nvmac_cfg_type act_cfg;
	logic [7:0] nv_trim = TRIM_INIT;
	logic [2:0] prog_sync;
	logic [2:0] bo_sync;
	logic prog;
	logic bo_seen;
	logic [11:0] idx;
	logic take;
	logic wr;
	logic dee_we;
	logic code_we;
	logic cfg_we;
	logic wr_block;
	logic rd_refuse;
	logic ee_busy;
	logic ee_done;
	logic [7:0] dmem_q;
	logic [7:0] cmem_q;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic [2:0] events;
	logic [7:0] next_data;

	////////////////////////////////////////////////////////////////////////////
	function automatic nvmac_pkg::nvmac_region_type decode(input logic [11:0] a);
		if (a <= `NVMAC_SRAM_LAST)
			decode = nvmac_pkg::RG_SRAM;
		else if (a <= `NVMAC_DEE_LAST)
			decode = nvmac_pkg::RG_DEE;
		else if (a >= `NVMAC_CODE_FIRST)
			decode = nvmac_pkg::RG_CODE;
		else if (a == `NVMAC_CFG1_IDX)
			decode = nvmac_pkg::RG_CFG1;
		else if (a == `NVMAC_CFG2_IDX)
			decode = nvmac_pkg::RG_CFG2;
		else if (a == `NVMAC_STAT_IDX)
			decode = nvmac_pkg::RG_STAT;
		else if (a == `NVMAC_ISTAT_IDX)
			decode = nvmac_pkg::RG_ISTAT;
		else if (a == `NVMAC_IMASK_IDX)
			decode = nvmac_pkg::RG_IMASK;
		else
			decode = nvmac_pkg::RG_NONE;
	endfunction

	function automatic logic is_mem(input nvmac_pkg::nvmac_region_type r);
		is_mem = (r == nvmac_pkg::RG_SRAM) || (r == nvmac_pkg::RG_DEE) ||
			(r == nvmac_pkg::RG_CODE);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pins from outside pass three flops; a change counts once the last two agree.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			prog_sync <= 3'h0;
			bo_sync <= 3'h0;
			prog <= 1'b0;
			bo_seen <= 1'b0;
		end
		else
		begin
			prog_sync <= {prog_sync[1:0], prog_mode_i};
			bo_sync <= {bo_sync[1:0], brownout_i};
			if (prog_sync[1] == prog_sync[2])
				prog <= prog_sync[2];
			if (bo_sync[1] == bo_sync[2])
				bo_seen <= bo_sync[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign idx = adr_i[13:2];
	assign region = decode(idx);
	assign take = !rst_i && (state == nvmac_pkg::ST_IDLE) && cyc_i && stb_i;
	assign wr = take && we_i && sel_i[0];

	// Write permission for each target; program mode honours write lockout.
	always_comb
	begin
		dee_we = 1'b0;
		code_we = 1'b0;
		cfg_we = 1'b0;
		wr_block = 1'b0;
		if (wr)
		begin
			if (region == nvmac_pkg::RG_DEE)
			begin
				dee_we = !ee_busy && !(prog && act_cfg.write_lockout);
				if (act_cfg.upper_block_lock && idx >= `NVMAC_UPPER_FIRST)
					dee_we = 1'b0;
				wr_block = !dee_we;
			end
			else if (region == nvmac_pkg::RG_CODE)
			begin
				code_we = prog && !act_cfg.write_lockout;
				wr_block = !code_we;
			end
			else if (region == nvmac_pkg::RG_CFG1 || region == nvmac_pkg::RG_CFG2)
			begin
				cfg_we = prog && !act_cfg.write_lockout;
				wr_block = !cfg_we;
			end
		end
	end

	assign rd_refuse = take && !we_i && prog && act_cfg.read_lockout && is_mem(region);

	////////////////////////////////////////////////////////////////////////////
	// SRAM and data EEPROM share one array; SRAM writes are always allowed.
	nvmac_mem #(
		.AW(7)
	) u_data_mem (
		.clk_i(clk_i),
		.we_i(dee_we || (wr && region == nvmac_pkg::RG_SRAM)),
		.addr_i(idx[6:0]),
		.wdata_i(dat_i[7:0]),
		.rdata_o(dmem_q)
	);

	nvmac_mem #(
		.AW(11)
	) u_code_mem (
		.clk_i(clk_i),
		.we_i(code_we),
		.addr_i(idx[10:0]),
		.wdata_i(dat_i[7:0]),
		.rdata_o(cmem_q)
	);

	nvmac_ee_timer #(
		.CYCLES(EE_CYCLES)
	) u_ee_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(dee_we),
		.busy_o(ee_busy),
		.done_o(ee_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// Nonvolatile copies of the two configuration bytes have no reset, so a
	// read lockout once set survives every restart.
	always_ff @(posedge clk_i)
	begin
		if (cfg_we && region == nvmac_pkg::RG_CFG1)
			nv_cfg <= dat_i[7:0] | (nv_cfg & `NVMAC_RDLOCK_MASK);
		else if (cfg_we && region == nvmac_pkg::RG_CFG2)
			nv_trim <= dat_i[7:0];
	end

	// Active copy is fetched once after reset; bus waits until both bytes are in.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			act_cfg <= `NVMAC_CFG1_RESET;
			osc_trim_o <= `NVMAC_TRIM_RESET;
		end
		else if (state == nvmac_pkg::ST_LOAD1)
		begin
			act_cfg <= nv_cfg;
		end
		else if (state == nvmac_pkg::ST_LOAD2)
		begin
			osc_trim_o <= nv_trim;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			low_battery_detect_on_o <= 1'b0;
			brownout_reset_o <= 1'b0;
			watchdog_on_o <= 1'b0;
			clock_mode_select_o <= 2'h0;
		end
		else
		begin
			low_battery_detect_on_o <= act_cfg.low_battery_detect_on;
			brownout_reset_o <= act_cfg.brownout_reset_on && bo_seen;
			watchdog_on_o <= act_cfg.watchdog_on;
			clock_mode_select_o <= {act_cfg.clk_mode_hi, act_cfg.clk_mode_lo};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus sequence: take, one cycle for the array read, then ack for one cycle.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= nvmac_pkg::ST_LOAD1;
			resp_region <= nvmac_pkg::RG_NONE;
		end
		else
		begin
			case (state)
				nvmac_pkg::ST_LOAD1: state <= nvmac_pkg::ST_LOAD2;
				nvmac_pkg::ST_LOAD2: state <= nvmac_pkg::ST_IDLE;
				nvmac_pkg::ST_IDLE:
				begin
					if (take)
					begin
						state <= nvmac_pkg::ST_RESP;
						resp_region <= rd_refuse || we_i ? nvmac_pkg::RG_NONE : region;
					end
				end
				nvmac_pkg::ST_RESP: state <= nvmac_pkg::ST_ACK;
				default: state <= nvmac_pkg::ST_IDLE;
			endcase
		end
	end

	always_comb
	begin
		next_data = 8'h00;
		case (resp_region)
			nvmac_pkg::RG_SRAM: next_data = dmem_q;
			nvmac_pkg::RG_DEE: next_data = dmem_q;
			nvmac_pkg::RG_CODE: next_data = cmem_q;
			nvmac_pkg::RG_CFG1: next_data = prog ? 8'(nv_cfg) : 8'h00;
			nvmac_pkg::RG_CFG2: next_data = prog ? nv_trim : 8'h00;
			nvmac_pkg::RG_STAT: next_data = {7'h00, !ee_busy};
			nvmac_pkg::RG_ISTAT: next_data = {5'h00, irq_stat};
			nvmac_pkg::RG_IMASK: next_data = {5'h00, irq_mask};
			default: next_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end
		else
		begin
			ack_o <= (state == nvmac_pkg::ST_RESP);
			if (state == nvmac_pkg::ST_RESP)
				dat_o <= {24'h000000, next_data};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky events; a new event wins over a write-one clear in the same cycle.
	assign events = {rd_refuse, wr_block, ee_done};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			irq_o <= 1'b0;
		end
		else
		begin
			if (wr && region == nvmac_pkg::RG_ISTAT)
				irq_stat <= (irq_stat & ~dat_i[2:0]) | events;
			else
				irq_stat <= irq_stat | events;
			if (wr && region == nvmac_pkg::RG_IMASK)
				irq_mask <= dat_i[2:0];
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	localparam int EE_BOUND = 1000;

	a_code_lock: assert property (@(posedge clk_i) disable iff (rst_i)
		code_we |-> prog && !act_cfg.write_lockout)
		else $error("code EEPROM written outside program mode or under lockout");
	a_upper_lock: assert property (@(posedge clk_i) disable iff (rst_i)
		dee_we && act_cfg.upper_block_lock |-> idx < `NVMAC_UPPER_FIRST)
		else $error("locked upper data EEPROM block written");
	a_ready_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		dee_we |=> ee_busy)
		else $error("ready flag did not drop after a data EEPROM write");
	a_ready_return: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ee_busy) |-> ##[1:EE_BOUND] (!ee_busy && ee_done))
		else $error("ready flag did not return after the write cycle");
	a_rdlock_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		nv_cfg.read_lockout |=> nv_cfg.read_lockout)
		else $error("read lockout bit was cleared");
	a_read_refused: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_refuse |-> ##2 (ack_o && dat_o == 32'h00000000))
		else $error("locked memory read returned data");
	a_write_lock: assert property (@(posedge clk_i) disable iff (rst_i)
		prog && act_cfg.write_lockout |-> !(dee_we || code_we || cfg_we))
		else $error("write accepted in program mode under write lockout");
	a_clock_mode: assert property (@(posedge clk_i) disable iff (rst_i)
		state == nvmac_pkg::ST_IDLE && $stable(act_cfg) |=>
		clock_mode_select_o == {$past(act_cfg.clk_mode_hi), $past(act_cfg.clk_mode_lo)})
		else $error("clock mode select bits misordered");
	a_brownout_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		brownout_reset_o |-> $past(act_cfg.brownout_reset_on) && $past(bo_seen))
		else $error("brown-out reset raised while not allowed");
	a_blocked_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_block |-> !dee_we && !code_we && !cfg_we ##1 !$rose(ee_busy))
		else $error("blocked write had an effect");

	c_dee_write: cover property (@(posedge clk_i) disable iff (rst_i)
		dee_we ##1 ee_busy);
	c_code_write: cover property (@(posedge clk_i) disable iff (rst_i) code_we);
	c_read_refuse: cover property (@(posedge clk_i) disable iff (rst_i) rd_refuse);
	c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule // nvmac_top
`default_nettype wire

// ===== shared/nvmac_consts.svh
// Offsets, field positions, reset values and timing counts of the memory access block.
`ifndef NVMAC_CONSTS_SVH
`define NVMAC_CONSTS_SVH
`define NVMAC_SRAM_LAST 12'h03f
`define NVMAC_DEE_FIRST 12'h040
`define NVMAC_DEE_LAST 12'h07f
`define NVMAC_UPPER_FIRST 12'h060
`define NVMAC_CODE_FIRST 12'h800
`define NVMAC_CFG1_IDX 12'h0bb
`define NVMAC_CFG2_IDX 12'h0bc
`define NVMAC_STAT_IDX 12'h0cf
`define NVMAC_ISTAT_IDX 12'h0d0
`define NVMAC_IMASK_IDX 12'h0d1
`define NVMAC_READY_BIT 0
`define NVMAC_EV_DONE 0
`define NVMAC_EV_BLOCK 1
`define NVMAC_EV_RDREF 2
`define NVMAC_CFG1_RESET 8'h00
`define NVMAC_TRIM_RESET 8'h80
`define NVMAC_RDLOCK_MASK 8'h01
`define NVMAC_EE_WRITE_NS 10000
`define NVMAC_CLK_NS 40
`define NVMAC_EE_WRITE_CYC ((`NVMAC_EE_WRITE_NS) / (`NVMAC_CLK_NS))
`endif

// ===== shared/nvmac_pkg.sv
// Types shared by the memory access block.
package nvmac_pkg;
	typedef enum logic [2:0] {ST_LOAD1, ST_LOAD2, ST_IDLE, ST_RESP, ST_ACK} nvmac_state_type;
	typedef enum logic [3:0] {RG_SRAM, RG_DEE, RG_CODE, RG_CFG1, RG_CFG2, RG_STAT,
		RG_ISTAT, RG_IMASK, RG_NONE} nvmac_region_type;
	typedef struct packed {
		logic clk_mode_lo;
		logic clk_mode_hi;
		logic watchdog_on;
		logic brownout_reset_on;
		logic low_battery_detect_on;
		logic upper_block_lock;
		logic write_lockout;
		logic read_lockout;
	} nvmac_cfg_type;
endpackage

// ===== logic/nvmac_mem.sv
// Byte-wide memory with registered read data.
`timescale 1ns/1ns
`default_nettype none
module nvmac_mem #(
	parameter int AW = 7
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] cells [0:(1<<AW)-1];
	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			cells[addr_i] <= wdata_i;
		end
		rdata_o <= cells[addr_i];
	end
endmodule // nvmac_mem
`default_nettype wire

// ===== logic/nvmac_ee_timer.sv
// Data EEPROM write cycle timer that holds busy for a fixed count.
`timescale 1ns/1ns
`default_nettype none
`include "nvmac_consts.svh"
module nvmac_ee_timer #(
	parameter int CYCLES = `NVMAC_EE_WRITE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	output logic busy_o,
	output logic done_o
);
	logic [15:0] count;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count <= 16'h0000;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end
		else if (start_i && !busy_o)
		begin
			count <= 16'(CYCLES - 1);
			busy_o <= 1'b1;
			done_o <= 1'b0;
		end
		else if (busy_o && count == 16'h0000)
		begin
			busy_o <= 1'b0;
			done_o <= 1'b1;
		end
		else
		begin
			count <= busy_o ? count - 16'h0001 : count;
			done_o <= 1'b0;
		end
	end
endmodule // nvmac_ee_timer
`default_nettype wire

// ===== bench/nvmac_host.sv
// Bus master model of the core and programmer for the memory access block.
`timescale 1ns/1ns
`default_nettype none
`include "nvmac_consts.svh"
module nvmac_host (
	// Clock.
	input wire logic clk_i,
	// Bus answer.
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	// Bus request.
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [13:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	initial
	begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 14'h0000;
		sel_o = 4'h0;
		dat_o = 32'h00000000;
	end
	////////////////////////////////////////////////////////////////////////
	// The request is held until ack is sampled; a bound stops a hang.
	task automatic xfer(input logic w, input logic [11:0] idx,
		input logic [7:0] wd, output logic [7:0] rd, output bit ok);
		int n;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= {idx, 2'b00};
		sel_o <= 4'h1;
		dat_o <= {24'h000000, wd};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_i !== 1'b1 && n < 64);
		ok = (ack_i === 1'b1);
		rd = dat_i[7:0];
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Software touches the array only once the ready flag reads one.
	task automatic ee_write(input logic [11:0] idx, input logic [7:0] wd,
		output bit ok);
		logic [7:0] s;
		int n;
		s = 8'h00;
		n = 0;
		ok = 1'b1;
		while (s[0] !== 1'b1 && n < 64 && ok)
		begin
			xfer(1'b0, `NVMAC_STAT_IDX, 8'h00, s, ok);
			n++;
		end
		if (ok && s[0] === 1'b1)
			xfer(1'b1, idx, wd, s, ok);
		else
			ok = 1'b0;
	endtask
endmodule // nvmac_host
`default_nettype wire

// ===== bench/nvm_access_and_init_config_test.sv
// Self-checking testbench of the memory access and configuration block.
`timescale 1ns/1ns
`default_nettype none
`include "nvmac_consts.svh"
module nvm_access_and_init_config_test;
	// Factory byte with both lockouts clear, so every gate can be reached.
	localparam logic [7:0] CFG1 = 8'hbc;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic prog_mode_i = 1'b0;
	logic brownout_i = 1'b0;
	logic cyc, stb, we, ack, lbd, bor, wdg, irq;
	logic [13:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [1:0] clock_mode_select;
	logic [7:0] trim, d;
	int n_mismatch = 0;
	int comparisons = 0;
	always #20 clk_i = ~clk_i;
	nvmac_host host_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
		.cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.dat_o(wdat));
	nvmac_top #(.CFG1_INIT(CFG1), .TRIM_INIT(8'h80), .EE_CYCLES(8)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.prog_mode_i(prog_mode_i), .brownout_i(brownout_i),
		.low_battery_detect_on_o(lbd), .brownout_reset_o(bor),
		.watchdog_on_o(wdg), .clock_mode_select_o(clock_mode_select),
		.osc_trim_o(trim), .irq_o(irq));
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check8(input string what, input logic [7:0] e,
		input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic check1(input string what, input logic e, input logic g);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic hang(input bit ok);
		if (!ok)
		begin
			n_mismatch++;
			$display("[ERR] bus answer expected ack seen none");
			print_verdict();
		end
	endtask
	task automatic rd(input logic [11:0] idx, output logic [7:0] v);
		bit ok;
		host_u.xfer(1'b0, idx, 8'h00, v, ok);
		hang(ok);
	endtask
	task automatic wr(input logic [11:0] idx, input logic [7:0] v);
		logic [7:0] x;
		bit ok;
		host_u.xfer(1'b1, idx, v, x, ok);
		hang(ok);
	endtask
	// The pins pass a synchroniser, so each change is given time to land.
	task automatic pins(input logic p, input logic b);
		@(posedge clk_i);
		prog_mode_i <= p;
		brownout_i <= b;
		repeat (6) @(posedge clk_i);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_config();
		check8("trim", 8'h80, trim);
		check1("low battery", 1'b1, lbd);
		check1("watchdog", 1'b1, wdg);
		check8("clock mode", 8'h01, {6'h00, clock_mode_select});
		check1("brownout idle", 1'b0, bor);
		pins(1'b0, 1'b1);
		check1("brownout", 1'b1, bor);
		pins(1'b0, 1'b0);
		rd(`NVMAC_STAT_IDX, d);
		check1("ready", 1'b1, d[0]);
		$display("config done");
	endtask
	task automatic t_sram();
		wr(12'h000, 8'ha5);
		wr(`NVMAC_SRAM_LAST, 8'h5a);
		rd(12'h000, d);
		check8("sram low", 8'ha5, d);
		rd(`NVMAC_SRAM_LAST, d);
		check8("sram high", 8'h5a, d);
		rd(12'h090, d);
		check8("unmapped", 8'h00, d);
		$display("sram done");
	endtask
	task automatic t_code();
		pins(1'b1, 1'b0);
		wr(`NVMAC_CODE_FIRST, 8'h3c);
		rd(`NVMAC_CODE_FIRST, d);
		check8("code prog", 8'h3c, d);
		pins(1'b0, 1'b0);
		wr(`NVMAC_CODE_FIRST, 8'hc3);
		rd(`NVMAC_CODE_FIRST, d);
		check8("code normal", 8'h3c, d);
		rd(`NVMAC_CFG1_IDX, d);
		check8("cfg normal", 8'h00, d);
		$display("code done");
	endtask
	task automatic t_eeprom();
		bit ok;
		int n;
		host_u.ee_write(12'h041, 8'h77, ok);
		hang(ok);
		rd(`NVMAC_STAT_IDX, d);
		check1("busy", 1'b0, d[0]);
		n = 0;
		while (d[0] !== 1'b1 && n < 64)
		begin
			rd(`NVMAC_STAT_IDX, d);
			n++;
		end
		check1("ready again", 1'b1, d[0]);
		rd(12'h041, d);
		check8("eeprom", 8'h77, d);
		host_u.ee_write(`NVMAC_UPPER_FIRST, 8'h99, ok);
		hang(ok);
		rd(`NVMAC_STAT_IDX, d);
		check1("locked no busy", 1'b1, d[0]);
		rd(`NVMAC_ISTAT_IDX, d);
		check8("events", 8'h03, d);
		$display("eeprom done");
	endtask
	task automatic t_irq();
		check1("irq masked", 1'b0, irq);
		wr(`NVMAC_IMASK_IDX, 8'h01);
		check1("irq on", 1'b1, irq);
		wr(`NVMAC_ISTAT_IDX, 8'h01);
		check1("irq off", 1'b0, irq);
		rd(`NVMAC_ISTAT_IDX, d);
		check8("w1c", 8'h02, d);
		$display("irq done");
	endtask
	task automatic t_prog_cfg();
		pins(1'b1, 1'b0);
		rd(`NVMAC_CFG1_IDX, d);
		check8("cfg prog", CFG1, d);
		rd(`NVMAC_CFG2_IDX, d);
		check8("trim prog", 8'h80, d);
		wr(`NVMAC_CFG1_IDX, CFG1 | 8'h01);
		wr(`NVMAC_CFG1_IDX, CFG1 | 8'h02);
		rd(`NVMAC_CFG1_IDX, d);
		check8("read lock sticky", CFG1 | 8'h03, d);
		pins(1'b0, 1'b0);
		$display("prog config done");
	endtask
	// A restart in mid-run loads both lockouts from the stored byte.
	task automatic t_lockout();
		pins(1'b1, 1'b0);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		check8("trim reload", 8'h80, trim);
		rd(`NVMAC_CFG1_IDX, d);
		check8("lock kept", CFG1 | 8'h03, d);
		rd(`NVMAC_CODE_FIRST, d);
		check8("read refused", 8'h00, d);
		wr(`NVMAC_CFG1_IDX, 8'h00);
		rd(`NVMAC_CFG1_IDX, d);
		check8("cfg write refused", CFG1 | 8'h03, d);
		rd(`NVMAC_ISTAT_IDX, d);
		check8("lock events", 8'h06, d);
		pins(1'b0, 1'b0);
		rd(`NVMAC_CODE_FIRST, d);
		check8("code normal read", 8'h3c, d);
		$display("lockout done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_config();
		t_sram();
		t_code();
		t_eeprom();
		t_irq();
		t_prog_cfg();
		t_lockout();
		print_verdict();
	end
endmodule // nvm_access_and_init_config_test
`default_nettype wire
